/* hw/flash_pkg.sv */
`default_nettype none
package flash_pkg;
    localparam int ADDR_W      = 18;
    localparam int DATA_W      = 16;
    localparam int N_MAIN      = 7;
    localparam int N_PARAM     = 8;
    localparam int N_BLOCKS    = N_MAIN + N_PARAM;
    localparam int MAIN_WORDS  = 32768;
    localparam int PARAM_WORDS = 4096;
    localparam int WORDS       = N_MAIN * MAIN_WORDS + N_PARAM * PARAM_WORDS;

    // pin command codes
    localparam logic [7:0] CMD_READ    = 8'hff;
    localparam logic [7:0] CMD_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR   = 8'h50;
    localparam logic [7:0] CMD_PROG    = 8'h40;
    localparam logic [7:0] CMD_ERASE   = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_LOCKSET = 8'h60;
    localparam logic [7:0] CMD_LOCK    = 8'h01;
    localparam logic [7:0] CMD_UNLOCK  = 8'hd0;

    // register map (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LOCKS  = 4'h8;

    localparam int CTRL_EN_BIT   = 0;
    localparam int ST_BUSY_BIT   = 0;
    localparam int ST_LKDN_BIT   = 1;
    localparam int ST_RST_BIT    = 2;
    localparam int ST_LOCKER_BIT = 3;
    localparam int ST_VPPER_BIT  = 4;
    localparam int ST_SEQER_BIT  = 5;
    localparam logic CTRL_EN_RESET = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic              ceN;
        logic              oeN;
        logic              weN;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } pin_bus_t;

    typedef enum logic [2:0] {
        S_READ        = 3'b000,
        S_PROG_SETUP  = 3'b001,
        S_ERASE_SETUP = 3'b011,
        S_ERASING     = 3'b010,
        S_LOCK_SETUP  = 3'b110
    } state_t;

    function automatic logic [3:0] blockOf(input logic [ADDR_W-1:0] a);
        if (a[17:15] != 3'h7) begin
            return {1'b0, a[17:15]};
        end
        return 4'(4'h7 + {1'b0, a[14:12]});
    endfunction
endpackage
`default_nettype wire

/* hw/flash_protect_core.sv */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 4 Mbit: seven 32K main, eight 4K top blocks
// - write-protect low: lock changes ignored
// - write-protect high: lock commands take effect
// - flash reset low: outputs off, activity halted
// - after reset every block is locked
// - reset release returns to read-array mode
// - low program voltage inhibits program and erase
// - program voltage sampled only at operation start
module flash_protect_core (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [3:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic      [1:0]  bresp,
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [3:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    input  wire logic        flash_chip_enable_n,
    input  wire logic        read_strobe_n,
    input  wire logic        writeStrobe_n,
    input  wire logic [17:0] addrPin,
    input  wire logic [15:0] dataPinIn,
    output logic      [15:0] dataPinOut,
    output logic             dataPinOe,
    input  wire logic        flashResetPin_n,
    input  wire logic        writeProtectPin_n,
    input  wire logic        vppEnablePin
);
    localparam int NB = flash_pkg::N_BLOCKS;
    localparam int SW = $bits(flash_pkg::pin_bus_t) + 3;
    localparam logic [SW-1:0] SYNC_INIT = {3'b111, {SW-6{1'b0}}, 3'b000};

    flash_pkg::pin_bus_t busS;
    logic                flashRstS_n;
    logic                wpS_n;
    logic                vppS;
    logic [15:0]         mem [0:flash_pkg::WORDS-1];

    pin_sync #(.W(SW), .INIT(SYNC_INIT)) u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .din   ({flash_chip_enable_n, read_strobe_n, writeStrobe_n, addrPin, dataPinIn,
                 flashResetPin_n, writeProtectPin_n, vppEnablePin}),
        .dout  ({busS, flashRstS_n, wpS_n, vppS})
    );

    flash_pkg::state_t state_r;
    logic              statusMode_r;
    logic [NB-1:0]     lockBits_r;
    logic [17:0]       eraseAddr_r;
    logic [14:0]       eraseCnt_r;
    logic              wePrev_r;
    logic              cePrev_r;
    logic [17:0]       addrPrev_r;
    logic              dataValid_r;
    logic [15:0]       readData_r;
    logic              ctrlEn_r;
    logic              lockErr_r;
    logic              vppErr_r;
    logic              seqErr_r;

    logic       resetActive;
    logic       cmd;
    logic [7:0] cmdCode;
    logic [3:0] curBlock;
    logic       curLocked;
    logic       progReq;
    logic       eraseReq;
    logic       progGo;
    logic       eraseGo;
    logic       lockCmd;
    logic       memWe;
    logic [17:0] memAddr;
    logic       clrPin;
    logic       lockErrSet;
    logic       vppErrSet;
    logic       seqErrSet;
    logic       regWr;
    logic [2:0] stClr;

    assign resetActive = ~flashRstS_n;
    assign cmd       = busS.weN & ~wePrev_r & ~cePrev_r & ctrlEn_r & ~resetActive;
    assign cmdCode   = busS.data[7:0];
    assign curBlock  = flash_pkg::blockOf(busS.addr);
    assign curLocked = lockBits_r[curBlock];
    assign progReq   = cmd && state_r == flash_pkg::S_PROG_SETUP;
    assign eraseReq  = cmd && state_r == flash_pkg::S_ERASE_SETUP
                       && cmdCode == flash_pkg::CMD_CONFIRM;
    assign progGo    = progReq && vppS && !curLocked;
    assign eraseGo   = eraseReq && vppS && !curLocked;
    assign lockCmd   = cmd && state_r == flash_pkg::S_LOCK_SETUP && wpS_n;
    assign memWe     = progGo || (state_r == flash_pkg::S_ERASING && !resetActive);
    assign memAddr   = progGo ? busS.addr : eraseAddr_r;
    assign clrPin    = cmd && state_r == flash_pkg::S_READ && cmdCode == flash_pkg::CMD_CLEAR;
    assign lockErrSet = (progReq || eraseReq) && vppS && curLocked;
    assign vppErrSet  = (progReq || eraseReq) && !vppS;
    assign seqErrSet  = cmd && state_r == flash_pkg::S_ERASE_SETUP
                        && cmdCode != flash_pkg::CMD_CONFIRM;

    // strobe edge tracking
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wePrev_r   <= 1'b1;
            cePrev_r   <= 1'b1;
            addrPrev_r <= '0;
        end else begin
            wePrev_r   <= busS.weN;
            cePrev_r   <= busS.ceN;
            addrPrev_r <= busS.addr;
        end
    end

    // command state machine and block locks
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r      <= flash_pkg::S_READ;
            statusMode_r <= 1'b0;
            lockBits_r   <= '1;
            eraseAddr_r  <= '0;
            eraseCnt_r   <= '0;
        end else if (resetActive) begin
            state_r      <= flash_pkg::S_READ;
            statusMode_r <= 1'b0;
            lockBits_r   <= '1;
            eraseCnt_r   <= '0;
        end else begin
            unique case (state_r)
                flash_pkg::S_READ: begin
                    if (cmd) begin
                        unique case (cmdCode)
                            flash_pkg::CMD_READ:    statusMode_r <= 1'b0;
                            flash_pkg::CMD_STATUS:  statusMode_r <= 1'b1;
                            flash_pkg::CMD_PROG:    state_r <= flash_pkg::S_PROG_SETUP;
                            flash_pkg::CMD_ERASE:   state_r <= flash_pkg::S_ERASE_SETUP;
                            flash_pkg::CMD_LOCKSET: state_r <= flash_pkg::S_LOCK_SETUP;
                            default: begin
                            end
                        endcase
                    end
                end
                flash_pkg::S_PROG_SETUP: begin
                    if (cmd) begin
                        state_r      <= flash_pkg::S_READ;
                        statusMode_r <= 1'b1;
                    end
                end
                flash_pkg::S_ERASE_SETUP: begin
                    if (cmd) begin
                        statusMode_r <= 1'b1;
                        state_r      <= eraseGo ? flash_pkg::S_ERASING : flash_pkg::S_READ;
                        if (busS.addr[17:15] == 3'h7) begin
                            eraseAddr_r <= {busS.addr[17:12], 12'h000};
                            eraseCnt_r  <= 15'(flash_pkg::PARAM_WORDS - 1);
                        end else begin
                            eraseAddr_r <= {busS.addr[17:15], 15'h0000};
                            eraseCnt_r  <= 15'(flash_pkg::MAIN_WORDS - 1);
                        end
                    end
                end
                flash_pkg::S_ERASING: begin
                    // supply level is not looked at again once running
                    eraseAddr_r <= 18'(eraseAddr_r + 18'h00001);
                    eraseCnt_r  <= 15'(eraseCnt_r - 15'h0001);
                    if (eraseCnt_r == '0) begin
                        state_r <= flash_pkg::S_READ;
                    end
                end
                flash_pkg::S_LOCK_SETUP: begin
                    if (cmd) begin
                        state_r <= flash_pkg::S_READ;
                    end
                    if (lockCmd && cmdCode == flash_pkg::CMD_LOCK) begin
                        lockBits_r[curBlock] <= 1'b1;
                    end else if (lockCmd && cmdCode == flash_pkg::CMD_UNLOCK) begin
                        lockBits_r[curBlock] <= 1'b0;
                    end
                end
            endcase
        end
    end

    // array; program can only clear bits, erase sets a whole block
    always_ff @(posedge clock) begin
        if (memWe) begin
            mem[memAddr] <= progGo ? (mem[memAddr] & busS.data) : 16'hffff;
        end
        readData_r <= mem[busS.addr];
    end

    // pin read path
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dataValid_r <= 1'b0;
            dataPinOut  <= '0;
            dataPinOe   <= 1'b0;
        end else begin
            if (resetActive) begin
                dataValid_r <= 1'b0;
            end else if ((cePrev_r && !busS.ceN) || addrPrev_r != busS.addr) begin
                dataValid_r <= 1'b1;
            end
            dataPinOe <= ~resetActive & ~busS.ceN & ~busS.oeN & busS.weN;
            if (statusMode_r) begin
                dataPinOut <= {8'h00, state_r != flash_pkg::S_ERASING, 1'b0,
                               seqErr_r, vppErr_r, lockErr_r, 3'b000};
            end else if (dataValid_r) begin
                dataPinOut <= readData_r;
            end
        end
    end

    // bus slave
    logic       awHeld_r;
    logic       wHeld_r;
    logic [3:0] awAddr_r;
    logic [31:0] wData_r;
    logic       wStrb0_r;

    assign awready = ~awHeld_r & ~bvalid;
    assign wready  = ~wHeld_r & ~bvalid;
    assign arready = ~rvalid;
    assign regWr   = awHeld_r & wHeld_r & ~bvalid;
    assign stClr   = (regWr && awAddr_r == flash_pkg::REG_STATUS && wStrb0_r)
                     ? wData_r[flash_pkg::ST_SEQER_BIT:flash_pkg::ST_LOCKER_BIT] : 3'b000;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= '0;
            wData_r  <= '0;
            wStrb0_r <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= flash_pkg::RESP_OKAY;
            ctrlEn_r <= flash_pkg::CTRL_EN_RESET;
        end else begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r  <= 1'b1;
                wData_r  <= wdata;
                wStrb0_r <= wstrb[0];
            end
            if (regWr) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= (awAddr_r == flash_pkg::REG_CTRL || awAddr_r == flash_pkg::REG_STATUS
                             || awAddr_r == flash_pkg::REG_LOCKS)
                            ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
                if (awAddr_r == flash_pkg::REG_CTRL && wStrb0_r) begin
                    ctrlEn_r <= wData_r[flash_pkg::CTRL_EN_BIT];
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // sticky errors: a new event wins over a clear
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lockErr_r <= 1'b0;
            vppErr_r  <= 1'b0;
            seqErr_r  <= 1'b0;
        end else begin
            lockErr_r <= lockErrSet | (lockErr_r & ~stClr[0] & ~clrPin);
            vppErr_r  <= vppErrSet | (vppErr_r & ~stClr[1] & ~clrPin);
            seqErr_r  <= seqErrSet | (seqErr_r & ~stClr[2] & ~clrPin);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= flash_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp  <= flash_pkg::RESP_OKAY;
            unique case (araddr)
                flash_pkg::REG_CTRL:   rdata <= {31'h0, ctrlEn_r};
                flash_pkg::REG_STATUS: rdata <= {26'h0, seqErr_r, vppErr_r, lockErr_r,
                                                 resetActive, ~wpS_n,
                                                 state_r == flash_pkg::S_ERASING};
                flash_pkg::REG_LOCKS:  rdata <= {17'h0, lockBits_r};
                default: begin
                    rdata <= '0;
                    rresp <= flash_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // assertions
    AST_BLOCK_MAP: assert property (@(posedge clock) disable iff (!rst_b)
        (eraseGo && busS.addr[17:15] == 3'h7) |=> eraseCnt_r == 15'h0fff)
        else $error("parameter block erase length wrong");
    AST_LOCKDOWN: assert property (@(posedge clock) disable iff (!rst_b)
        (cmd && state_r == flash_pkg::S_LOCK_SETUP && !wpS_n) |=> $stable(lockBits_r))
        else $error("lock state changed under lock-down");
    AST_UNLOCK: assert property (@(posedge clock) disable iff (!rst_b)
        (lockCmd && cmdCode == flash_pkg::CMD_UNLOCK && !resetActive)
        |=> !lockBits_r[$past(curBlock)])
        else $error("unlock not applied");
    AST_RESET_HIZ: assert property (@(posedge clock) disable iff (!rst_b)
        resetActive |=> !dataPinOe && !memWe)
        else $error("outputs driven during flash reset");
    AST_RESET_LOCK: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(resetActive) |-> &lockBits_r)
        else $error("blocks not locked after reset");
    AST_READ_MODE: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(resetActive) |-> state_r == flash_pkg::S_READ && !statusMode_r)
        else $error("not in read array after reset");
    AST_VPP_INHIBIT: assert property (@(posedge clock) disable iff (!rst_b)
        ((progReq || eraseReq) && !vppS) |-> !memWe ##1 state_r != flash_pkg::S_ERASING)
        else $error("operation started with low program voltage");
    AST_VPP_ONCE: assert property (@(posedge clock) disable iff (!rst_b || resetActive)
        (state_r == flash_pkg::S_ERASING && eraseCnt_r != '0) |=> state_r == flash_pkg::S_ERASING)
        else $error("erase aborted while running");
    AST_LOCKED_KEEP: assert property (@(posedge clock) disable iff (!rst_b)
        memWe |-> !lockBits_r[flash_pkg::blockOf(memAddr)])
        else $error("write into locked block");
endmodule
`default_nettype wire

/* hw/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int         W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1_r;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= INIT;
            dout     <= INIT;
        end else begin
            stage1_r <= din;
            dout     <= stage1_r;
        end
    end
endmodule
`default_nettype wire

/* test/flash_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_model (
    input  wire logic        clock,
    input  wire logic [15:0] dataPinOut,
    input  wire logic        dataPinOe,
    output logic             bank0_select_n,
    output logic             read_strobe_n,
    output logic             writeStrobe_n,
    output logic      [17:0] addrPin,
    output logic      [15:0] dataPinIn
);
    logic        drv;
    logic [15:0] wrData;
    // data lines carry pull-downs when nobody drives them
    assign dataPinIn = dataPinOe ? dataPinOut : (drv ? wrData : 16'h0000);
    initial begin
        bank0_select_n = 1'b1;
        read_strobe_n  = 1'b1;
        writeStrobe_n  = 1'b1;
        addrPin        = 18'h00000;
        drv            = 1'b0;
        wrData         = 16'h0000;
    end
    // one write cycle on the bank zero select
    task automatic pinWrite(input logic [17:0] a, input logic [15:0] v);
        @(posedge clock);
        bank0_select_n <= 1'b0;
        addrPin        <= a;
        wrData         <= v;
        drv            <= 1'b1;
        repeat (2) @(posedge clock);
        writeStrobe_n <= 1'b0;
        repeat (4) @(posedge clock);
        writeStrobe_n <= 1'b1;
        repeat (4) @(posedge clock);
        drv            <= 1'b0;
        bank0_select_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    // every read starts with a fresh select falling edge
    task automatic selectRead(input logic [17:0] a);
        @(posedge clock);
        bank0_select_n <= 1'b0;
        read_strobe_n  <= 1'b0;
        addrPin        <= a;
    endtask
    task automatic deselect();
        @(posedge clock);
        bank0_select_n <= 1'b1;
        read_strobe_n  <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    task automatic pinRead(input logic [17:0] a, output logic [15:0] v, output logic e);
        selectRead(a);
        repeat (10) @(posedge clock);
        v = dataPinOut;
        e = dataPinOe;
        deselect();
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0] ST = flash_pkg::REG_STATUS;
    localparam logic [3:0] LK = flash_pkg::REG_LOCKS;
    logic        clock = 1'b0, rst_b = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic [31:0] wdata = 32'h0000_0000;
    logic        flashResetPin_n = 1'b0, writeProtectPin_n = 1'b0, vppEnablePin = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, dataPinOe;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic        flash_chip_enable_n, read_strobe_n, writeStrobe_n, oe;
    logic [17:0] addrPin;
    logic [15:0] dataPinIn, dataPinOut, keep;
    int          errors = 0, compares = 0, n;

    always #2 clock = ~clock;

    flash_protect_core u_flash_protect_core (
        .clock, .rst_b, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
        .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
        .rresp, .flash_chip_enable_n, .read_strobe_n, .writeStrobe_n, .addrPin,
        .dataPinIn, .dataPinOut, .dataPinOe, .flashResetPin_n, .writeProtectPin_n,
        .vppEnablePin
    );
    flash_bus_model u_flash_bus_model (
        .clock, .dataPinOut, .dataPinOe, .bank0_select_n(flash_chip_enable_n),
        .read_strobe_n, .writeStrobe_n, .addrPin, .dataPinIn
    );

    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hung(input int got, input int lim);
        errors++;
        $display("ERROR at %0t: wait ran out got %h expected %h", $time, got, lim);
        conclude();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] v, output logic [1:0] s);
        int   k;
        logic aw, w, b;
        @(posedge clock);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        bready  <= 1'b1;
        k = 0;
        b = 1'b0;
        while (!b) begin
            @(negedge clock);
            aw = awvalid & awready;
            w  = wvalid & wready;
            b  = bvalid;
            s  = bresp;
            @(posedge clock);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
            k++;
            if (k > 100) hung(k, 100);
        end
    endtask
    task automatic axiRead(input logic [3:0] a, output logic [31:0] q, output logic [1:0] s);
        int   k;
        logic ar, rv;
        @(posedge clock);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        k  = 0;
        rv = 1'b0;
        while (!rv) begin
            @(negedge clock);
            ar = arvalid & arready;
            rv = rvalid;
            q  = rdata;
            s  = rresp;
            @(posedge clock);
            if (ar) arvalid <= 1'b0;
            if (rv) rready <= 1'b0;
            k++;
            if (k > 100) hung(k, 100);
        end
    endtask
    task automatic rdReg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        axiRead(a, d, r);
        check(d & m, e);
    endtask
    task automatic cmd2(input logic [17:0] a, input logic [15:0] c1, input logic [15:0] c2);
        u_flash_bus_model.pinWrite(a, c1);
        u_flash_bus_model.pinWrite(a, c2);
    endtask
    // back to read-array mode, then read one word
    task automatic rdPin(input logic [17:0] a, input logic [15:0] e);
        logic [15:0] v;
        logic        f;
        u_flash_bus_model.pinWrite(a, 16'h00ff);
        u_flash_bus_model.pinRead(a, v, f);
        check({16'h0000, v}, {16'h0000, e});
        check({31'h0, f}, 32'h1);
    endtask

    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (6) @(posedge clock);
        rdReg(ST, 32'h4, 32'h4);
        check({31'h0, dataPinOe}, 32'h0);
        rdReg(LK, 32'hffff_ffff, 32'h7fff);
        axiRead(4'hc, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, flash_pkg::RESP_SLVERR});
        axiWrite(4'hc, 32'h1, r);
        check({30'h0, r}, {30'h0, flash_pkg::RESP_SLVERR});
        flashResetPin_n <= 1'b1;
        repeat (6) @(posedge clock);
        rdReg(ST, 32'h4, 32'h0);
        cmd2(18'h38000, 16'h0060, 16'h00d0);
        rdReg(LK, 32'hffff_ffff, 32'h7fff);
        rdReg(ST, 32'h2, 32'h2);
        writeProtectPin_n <= 1'b1;
        repeat (6) @(posedge clock);
        rdReg(ST, 32'h2, 32'h0);
        cmd2(18'h38000, 16'h0060, 16'h00d0);
        rdReg(LK, 32'hffff_ffff, 32'h7f7f);
        cmd2(18'h38000, 16'h0060, 16'h0001);
        rdReg(LK, 32'hffff_ffff, 32'h7fff);
        cmd2(18'h38000, 16'h0060, 16'h00d0);
        rdReg(LK, 32'hffff_ffff, 32'h7f7f);
        vppEnablePin <= 1'b1;
        cmd2(18'h38000, 16'h0020, 16'h00d0);
        vppEnablePin <= 1'b0;
        rdReg(ST, 32'h1, 32'h1);
        n = 0;
        d = 32'h1;
        while (d[0] === 1'b1) begin
            axiRead(ST, d, r);
            n++;
            if (n > 3000) hung(n, 3000);
        end
        rdReg(ST, 32'h38, 32'h0);
        rdPin(18'h38000, 16'hffff);
        rdPin(18'h38fff, 16'hffff);
        vppEnablePin <= 1'b1;
        cmd2(18'h38005, 16'h0040, 16'h1234);
        rdPin(18'h38005, 16'h1234);
        cmd2(18'h38fff, 16'h0040, 16'h00ff);
        rdPin(18'h38fff, 16'h00ff);
        cmd2(18'h39000, 16'h0040, 16'h0000);
        rdReg(ST, 32'h8, 32'h8);
        cmd2(18'h38000, 16'h0060, 16'h0001);
        cmd2(18'h38005, 16'h0040, 16'h0000);
        rdPin(18'h38005, 16'h1234);
        cmd2(18'h38000, 16'h0060, 16'h00d0);
        axiWrite(ST, 32'h38, r);
        rdReg(ST, 32'h38, 32'h0);
        vppEnablePin <= 1'b0;
        cmd2(18'h38000, 16'h0020, 16'h00d0);
        rdReg(ST, 32'h10, 32'h10);
        u_flash_bus_model.pinRead(18'h38005, keep, oe);
        check({16'h0000, keep}, 32'h0090);
        rdPin(18'h38005, 16'h1234);
        u_flash_bus_model.pinWrite(18'h38005, 16'h0050);
        u_flash_bus_model.pinWrite(18'h38005, 16'h0070);
        axiWrite(4'h0, 32'h0, r);
        u_flash_bus_model.pinWrite(18'h38005, 16'h00ff);
        u_flash_bus_model.pinRead(18'h38005, keep, oe);
        check({16'h0000, keep}, 32'h0080);
        rdReg(4'h0, 32'h1, 32'h0);
        axiWrite(4'h0, 32'h1, r);
        cmd2(18'h38000, 16'h0020, 16'h00ff);
        rdReg(ST, 32'h20, 32'h20);
        axiWrite(ST, 32'h38, r);
        u_flash_bus_model.selectRead(18'h38005);
        repeat (10) @(posedge clock);
        check({31'h0, dataPinOe}, 32'h1);
        flashResetPin_n <= 1'b0;
        repeat (6) @(posedge clock);
        check({31'h0, dataPinOe}, 32'h0);
        rdReg(LK, 32'hffff_ffff, 32'h7fff);
        u_flash_bus_model.deselect();
        flashResetPin_n <= 1'b1;
        vppEnablePin    <= 1'b1;
        repeat (6) @(posedge clock);
        u_flash_bus_model.pinRead(18'h38005, keep, oe);
        check({16'h0000, keep}, 32'h1234);
        cmd2(18'h38005, 16'h0040, 16'h0000);
        rdReg(ST, 32'h8, 32'h8);
        rdPin(18'h38005, 16'h1234);
        conclude();
    end
endmodule
`default_nettype wire
